// ---- hw/fppr_pkg.sv ----
// package: widths, byte layout, reset values and offset choices for the fifo port control
package fppr_pkg;
  localparam int unsigned DATA_W      = 36;
  localparam int unsigned BYTE_W      = 9;
  localparam int unsigned NUM_BYTES   = 4;
  localparam int unsigned RST_EDGES   = 4;
  localparam logic [2:0]  RST_CNT_MAX = 3'h4;
  localparam logic [1:0]  OFFSET_RST  = 2'h0;
  localparam logic        AF_RST      = 1'b1;
  localparam logic        MBF_RST     = 1'b1;
  localparam logic        EF_RST      = 1'b0;
  localparam logic        AE_RST      = 1'b0;
  localparam logic        FF_RST      = 1'b0;

  typedef struct packed {
    logic almost_full_flag;
    logic almost_empty_flag;
    logic empty_flag;
    logic full_flag;
    logic mailbox_a_to_b_flag;
    logic mailbox_b_to_a_flag;
  } fppr_flags_s;

  typedef enum logic [1:0] {
    FPPR_IN_RESET = 2'b00,
    FPPR_RUN      = 2'b01
  } fppr_state_e;
endpackage

// ---- hw/fppr_port_ctrl.sv ----
// port control: direction, output enables, parity generation and reset sequencing
// Functional notes
// - port a generates parity on b-to-a mailbox reads when enabled
// - port a bytes are 9 bits; parity goes in each byte msb
// - port b generates parity on all reads, fifo or mailbox, when enabled
// - port b bytes are 9 bits; parity replaces each byte msb
// - parity sense follows the current shared sense input
// - reset completes after four edges of each port clock while low
// - reset sets almost-full and mailbox flags high, others low
// - offset selects captured when reset releases, choose threshold offset
// - port a direction high means write, low means read
// - port a outputs float while port a direction is high
// - port b direction high means write, low means read
// - port b outputs float while port b direction is high
// - sense high gives odd parity, low gives even
// - port a mailbox select steers access to a mailbox
// - port a mailbox read with generation forces parity error high
`timescale 1ns/10ps
module fppr_port_ctrl #(
  parameter int unsigned DATA_W = fppr_pkg::DATA_W
) (
  input  wire logic              clk_in,                    // single clock, 25 mhz
  input  wire logic              reset_n_in,                // async reset, active low
  input  wire logic              port_a_clock_in,           // port a clock level, sampled
  input  wire logic              port_b_clock_in,           // port b clock level, sampled
  input  wire logic              port_a_gate_in,            // port a enable
  input  wire logic              port_b_gate_in,            // port b enable
  input  wire logic              port_a_direction_select_in,// 1 write, 0 read
  input  wire logic              port_b_direction_select_in,// 1 write, 0 read
  input  wire logic              port_a_mailbox_select_in,  // port a mailbox select
  input  wire logic              port_b_mailbox_select_in,  // port b mailbox select
  input  wire logic              port_a_parity_gen_in,      // port a parity generation
  input  wire logic              port_b_parity_gen_in,      // port b parity generation
  input  wire logic              parity_odd_in,             // 1 odd, 0 even
  input  wire logic              offset_select_hi_in,       // offset select high bit
  input  wire logic              offset_select_lo_in,       // offset select low bit
  input  wire logic [DATA_W-1:0] port_a_read_data_in,       // b-to-a mailbox word
  input  wire logic [DATA_W-1:0] port_b_fifo_data_in,       // fifo output word
  input  wire logic [DATA_W-1:0] port_b_mail_data_in,       // a-to-b mailbox word
  input  wire logic [DATA_W-1:0] port_a_data_bus_in,        // port a pins in
  input  wire logic              parity_error_a_raw_in,     // checker result, 1 ok
  input  wire fppr_pkg::fppr_flags_s flags_in,              // run-time flags
  output logic      [DATA_W-1:0] port_a_data_bus_out,       // port a pins out
  output logic                   port_a_data_bus_oe_out,    // port a drive enable
  output logic      [DATA_W-1:0] port_b_data_bus_out,       // port b pins out
  output logic                   port_b_data_bus_oe_out,    // port b drive enable
  output logic                   port_a_write_out,          // port a write taken
  output logic                   port_a_read_out,           // port a read taken
  output logic                   port_a_mailbox_out,        // port a access is mailbox
  output logic                   port_b_write_out,          // port b write taken
  output logic                   port_b_read_out,           // port b read taken
  output logic                   port_a_parity_error_out,   // port a parity flag
  output logic      [1:0]        offset_sel_out,            // latched offset choice
  output logic                   reset_done_out,            // reset sequence complete
  output fppr_pkg::fppr_flags_s  flags_out                  // flags presented at pins
);

  ////////////////////////////////////////////////////////////////////////////
  // parity helper
  function automatic logic [DATA_W-1:0] gen_parity(input logic [DATA_W-1:0] d,
                                                    input logic odd);
    logic [DATA_W-1:0] r;
    r = d;
    for (int i = 0; i < fppr_pkg::NUM_BYTES; i++) begin
      // parity bit makes the byte's ones count odd when odd is set
      r[i*fppr_pkg::BYTE_W+fppr_pkg::BYTE_W-1] =
        ^d[i*fppr_pkg::BYTE_W +: fppr_pkg::BYTE_W-1] ^ odd;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge detect and reset edge counters on sampled port clocks
  // no async reset here: it would pin the counters at zero for exactly the
  // span in which they must count; any edge with reset high clears them, so
  // the very first reset needs one such edge ahead of it
  logic       a_clk_q_reg, a_clk_q_next;
  logic       b_clk_q_reg, b_clk_q_next;
  logic       a_rise, b_rise;
  logic [2:0] a_cnt_reg, a_cnt_next;
  logic [2:0] b_cnt_reg, b_cnt_next;
  assign a_rise = port_a_clock_in & ~a_clk_q_reg;
  assign b_rise = port_b_clock_in & ~b_clk_q_reg;

  always_comb begin
    a_clk_q_next = port_a_clock_in;
    b_clk_q_next = port_b_clock_in;
    a_cnt_next   = 3'h0;
    b_cnt_next   = 3'h0;
    if (!reset_n_in) begin
      a_cnt_next = a_cnt_reg;
      b_cnt_next = b_cnt_reg;
      // saturate so a long reset never wraps back below the limit
      if (a_rise && a_cnt_reg != fppr_pkg::RST_CNT_MAX) begin
        a_cnt_next = a_cnt_reg + 3'h1;
      end
      if (b_rise && b_cnt_reg != fppr_pkg::RST_CNT_MAX) begin
        b_cnt_next = b_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    a_clk_q_reg <= a_clk_q_next;
    b_clk_q_reg <= b_clk_q_next;
    a_cnt_reg   <= a_cnt_next;
    b_cnt_reg   <= b_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequence: the first edge after release stands in for the release
  // edge itself; it latches the offset and judges the counts kept from reset
  logic       rst_seen_reg, rst_seen_next;
  logic [1:0] offset_reg, offset_next;
  fppr_pkg::fppr_state_e state_reg, state_next;

  always_comb begin
    rst_seen_next = rst_seen_reg;
    offset_next   = offset_reg;
    state_next    = state_reg;
    case (state_reg)
      fppr_pkg::FPPR_IN_RESET: begin
        if (!rst_seen_reg) begin
          rst_seen_next = 1'b1;
          offset_next   = {offset_select_hi_in, offset_select_lo_in};
          // too short a reset parks the block here until the next one
          if (a_cnt_reg == fppr_pkg::RST_CNT_MAX && b_cnt_reg == fppr_pkg::RST_CNT_MAX) begin
            state_next = fppr_pkg::FPPR_RUN;
          end
        end
      end
      fppr_pkg::FPPR_RUN: begin
        state_next = fppr_pkg::FPPR_RUN;
      end
      default: begin
        state_next = fppr_pkg::FPPR_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_seen_reg <= 1'b0;
      offset_reg   <= fppr_pkg::OFFSET_RST;
      state_reg    <= fppr_pkg::FPPR_IN_RESET;
    end else begin
      rst_seen_reg <= rst_seen_next;
      offset_reg   <= offset_next;
      state_reg    <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port datapath and strobes
  logic              run;
  logic [DATA_W-1:0] a_dout_next, b_dout_next, b_src;
  logic              a_oe_next, b_oe_next;
  logic              a_wr_next, a_rd_next, a_mb_next, b_wr_next, b_rd_next;
  logic              port_a_parity_error_next;
  fppr_pkg::fppr_flags_s flags_next;

  assign run = (state_reg == fppr_pkg::FPPR_RUN);

  always_comb begin
    // transfers only on a gated edge once the reset sequence is done
    a_wr_next = run & a_rise & port_a_gate_in & port_a_direction_select_in;
    a_rd_next = run & a_rise & port_a_gate_in & ~port_a_direction_select_in;
    a_mb_next = port_a_mailbox_select_in;
    b_wr_next = run & b_rise & port_b_gate_in & port_b_direction_select_in;
    b_rd_next = run & b_rise & port_b_gate_in & ~port_b_direction_select_in;
    a_oe_next = ~port_a_direction_select_in;
    b_oe_next = ~port_b_direction_select_in;
    b_src = port_b_mailbox_select_in ? port_b_mail_data_in : port_b_fifo_data_in;
    // port a only drives mailbox data; generation applies to mailbox reads only
    if (port_a_parity_gen_in && port_a_mailbox_select_in) begin
      a_dout_next = gen_parity(port_a_read_data_in, parity_odd_in);
    end else begin
      a_dout_next = port_a_read_data_in;
    end
    if (port_b_parity_gen_in) begin
      b_dout_next = gen_parity(b_src, parity_odd_in);
    end else begin
      b_dout_next = b_src;
    end
    // shared parity tree is busy generating, so the checker reads as clean
    if (port_a_gate_in && !port_a_direction_select_in && port_a_mailbox_select_in &&
        port_a_parity_gen_in) begin
      port_a_parity_error_next = 1'b1;
    end else begin
      port_a_parity_error_next = parity_error_a_raw_in;
    end
    if (run) begin
      flags_next = flags_in;
    end else begin
      flags_next = '{almost_full_flag:    fppr_pkg::AF_RST,
                     almost_empty_flag:   fppr_pkg::AE_RST,
                     empty_flag:          fppr_pkg::EF_RST,
                     full_flag:           fppr_pkg::FF_RST,
                     mailbox_a_to_b_flag: fppr_pkg::MBF_RST,
                     mailbox_b_to_a_flag: fppr_pkg::MBF_RST};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port_a_data_bus_out     <= '0;
      port_a_data_bus_oe_out  <= 1'b0;
      port_b_data_bus_out     <= '0;
      port_b_data_bus_oe_out  <= 1'b0;
      port_a_write_out        <= 1'b0;
      port_a_read_out         <= 1'b0;
      port_a_mailbox_out      <= 1'b0;
      port_b_write_out        <= 1'b0;
      port_b_read_out         <= 1'b0;
      port_a_parity_error_out <= 1'b1;
      offset_sel_out          <= fppr_pkg::OFFSET_RST;
      reset_done_out          <= 1'b0;
      flags_out               <= '{almost_full_flag:    fppr_pkg::AF_RST,
                                   almost_empty_flag:   fppr_pkg::AE_RST,
                                   empty_flag:          fppr_pkg::EF_RST,
                                   full_flag:           fppr_pkg::FF_RST,
                                   mailbox_a_to_b_flag: fppr_pkg::MBF_RST,
                                   mailbox_b_to_a_flag: fppr_pkg::MBF_RST};
    end else begin
      port_a_data_bus_out     <= a_dout_next;
      port_a_data_bus_oe_out  <= a_oe_next;
      port_b_data_bus_out     <= b_dout_next;
      port_b_data_bus_oe_out  <= b_oe_next;
      port_a_write_out        <= a_wr_next;
      port_a_read_out         <= a_rd_next;
      port_a_mailbox_out      <= a_mb_next;
      port_b_write_out        <= b_wr_next;
      port_b_read_out         <= b_rd_next;
      port_a_parity_error_out <= port_a_parity_error_next;
      offset_sel_out          <= offset_next;
      reset_done_out          <= run;
      flags_out               <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_a_float;
    @(posedge clk_in) disable iff (!reset_n_in)
      port_a_direction_select_in |=> !port_a_data_bus_oe_out;
  endproperty
  a_a_float: assert property (p_a_float) else $error("port a drives while writing");

  property p_b_float;
    @(posedge clk_in) disable iff (!reset_n_in)
      port_b_direction_select_in |=> !port_b_data_bus_oe_out;
  endproperty
  a_b_float: assert property (p_b_float) else $error("port b drives while writing");

  property p_port_a_parity_error_forced;
    @(posedge clk_in) disable iff (!reset_n_in)
      (port_a_gate_in && !port_a_direction_select_in && port_a_mailbox_select_in &&
       port_a_parity_gen_in) |=> port_a_parity_error_out;
  endproperty
  a_port_a_parity_error_forced: assert property (p_port_a_parity_error_forced) else $error("parity flag not forced");

  property p_b_parity;
    @(posedge clk_in) disable iff (!reset_n_in)
      port_b_parity_gen_in |=> ((^port_b_data_bus_out[8:0]) == $past(parity_odd_in));
  endproperty
  a_b_parity: assert property (p_b_parity) else $error("port b byte parity wrong");

  property p_b_pass;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!port_b_parity_gen_in && !port_b_mailbox_select_in) |=>
        port_b_data_bus_out == $past(port_b_fifo_data_in);
  endproperty
  a_b_pass: assert property (p_b_pass) else $error("port b data modified");

  property p_no_xfer_in_reset;
    @(posedge clk_in) disable iff (!reset_n_in)
      !run |=> !(port_a_write_out || port_a_read_out || port_b_write_out || port_b_read_out);
  endproperty
  a_no_xfer_in_reset: assert property (p_no_xfer_in_reset) else $error("transfer in reset");

  property p_rst_flags;
    @(posedge clk_in) disable iff (!reset_n_in)
      !run |=> (flags_out.almost_full_flag && !flags_out.empty_flag && !flags_out.full_flag);
  endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("reset flag values wrong");

  property p_offset_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      rst_seen_reg |=> $stable(offset_reg);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset changed after latch");

  property p_reset_parked;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!run && rst_seen_reg) |=> !run;
  endproperty
  a_reset_parked: assert property (p_reset_parked) else $error("left reset without edges");

  property p_a_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      (run && a_rise && port_a_gate_in && port_a_direction_select_in) |=>
        (port_a_write_out && !port_a_read_out);
  endproperty
  a_a_write: assert property (p_a_write) else $error("port a write not taken");

endmodule

// ---- tb/fppr_port_model.sv ----
// far-side model: port clocks and the port a pins of the bus controller
`timescale 1ns/10ps
module fppr_port_model #(
  parameter logic [35:0] DRIVE_WORD = 36'h1_2345_6789
) (
  input  wire logic        clk_in,        // bench clock
  input  wire logic        dut_oe_in,     // device drives port a pins
  output logic             port_a_clk_out, // port a clock level
  output logic             port_b_clk_out, // port b clock level
  output logic [35:0]      pins_a_out      // controller side of port a pins
);
  logic [2:0] cnt_a;
  logic [2:0] cnt_b;
  ////////////////////////////////////////////////////////////////////////////
  // both clocks run with a period of four bench clocks, also while reset is
  // low, so a 20-cycle reset always sees five rises of each; b lags a
  initial begin
    cnt_a          = 3'h0;
    cnt_b          = 3'h0;
    port_a_clk_out = 1'b0;
    port_b_clk_out = 1'b0;
    pins_a_out     = DRIVE_WORD;
    forever begin
      @(negedge clk_in);
      cnt_a          <= (cnt_a == 3'h3) ? 3'h0 : cnt_a + 3'h1;
      cnt_b          <= (cnt_b == 3'h3) ? 3'h0 : cnt_b + 3'h1;
      port_a_clk_out <= (cnt_a < 3'h2);
      port_b_clk_out <= (cnt_b == 3'h2);
      // bus driven by the device shows a changing pattern, never the last value; released bus shows DRIVE_WORD
      pins_a_out     <= dut_oe_in ? ~pins_a_out : DRIVE_WORD;
    end
  end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the fifo port control block
`timescale 1ns/10ps
module tb;
  logic clk_in, reset_n_in, a_gate, b_gate, dir, mbx, a_gen, b_gen, odd, off_hi, off_lo, raw_err;
  logic pa_clk, pb_clk, a_oe, b_oe, a_wr, a_rd, a_mb, b_wr, b_rd, perr, done;
  logic [35:0] a_pins, a_out, b_out;
  logic [1:0]  off_out;
  fppr_pkg::fppr_flags_s flags_in, flags_out;
  int miscompares, comparisons, n;
  localparam logic [35:0] A_WORD = 36'h5_A5C3_3F81;
  localparam logic [35:0] B_FIFO = 36'hC_0FF1_E7A2;
  localparam logic [35:0] B_MAIL = 36'h3_7E19_04D6;
  fppr_port_model far (.clk_in(clk_in), .dut_oe_in(a_oe), .port_a_clk_out(pa_clk),
    .port_b_clk_out(pb_clk), .pins_a_out(a_pins));
  fppr_port_ctrl dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .port_a_clock_in(pa_clk),
    .port_b_clock_in(pb_clk), .port_a_gate_in(a_gate), .port_b_gate_in(b_gate),
    .port_a_direction_select_in(dir), .port_b_direction_select_in(dir),
    .port_a_mailbox_select_in(mbx), .port_b_mailbox_select_in(mbx),
    .port_a_parity_gen_in(a_gen), .port_b_parity_gen_in(b_gen), .parity_odd_in(odd),
    .offset_select_hi_in(off_hi), .offset_select_lo_in(off_lo), .port_a_read_data_in(A_WORD),
    .port_b_fifo_data_in(B_FIFO), .port_b_mail_data_in(B_MAIL), .port_a_data_bus_in(a_pins),
    .parity_error_a_raw_in(raw_err), .flags_in(flags_in), .port_a_data_bus_out(a_out),
    .port_a_data_bus_oe_out(a_oe), .port_b_data_bus_out(b_out), .port_b_data_bus_oe_out(b_oe),
    .port_a_write_out(a_wr), .port_a_read_out(a_rd), .port_a_mailbox_out(a_mb),
    .port_b_write_out(b_wr), .port_b_read_out(b_rd), .port_a_parity_error_out(perr),
    .offset_sel_out(off_out), .reset_done_out(done), .flags_out(flags_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [35:0] with_par(input logic [35:0] d, input logic o);
    logic [35:0] r;
    r = d;
    for (int i = 0; i < 4; i++) r[9*i+8] = (^d[9*i +: 8]) ^ o;
    return r;
  endfunction
  // offset held through reset, changed right after the release edge
  task automatic do_reset(input logic [1:0] off);
    @(negedge clk_in);
    reset_n_in = 1'b0;
    {off_hi, off_lo} = off;
    flags_in = 6'b01_1100;
    repeat (20) @(negedge clk_in);
    check(flags_out, 6'b10_0011);
    check(done, 1'b0);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    {off_hi, off_lo} = ~off;
    check(flags_out, 6'b10_0011);
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk_in);
      n++;
    end
    // release to done: one edge into run, one more for the registered flag
    check(n, 36'h1);
    check(off_out, off);
    @(negedge clk_in);
    check(flags_out, flags_in);
  endtask
  // waits on the strobe of one port and checks its kind and width
  task automatic pulse_chk(input logic port_b, input logic wr);
    n = 0;
    while (((port_b ? (b_rd | b_wr) : (a_rd | a_wr)) !== 1'b1) && n < 12) begin
      @(negedge clk_in);
      n++;
    end
    check(n < 12, 1'b1);
    check(port_b ? {b_wr, b_rd} : {a_wr, a_rd}, {wr, !wr});
    @(negedge clk_in);
    check(port_b ? {b_wr, b_rd} : {a_wr, a_rd}, 2'b00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    miscompares = 0;
    comparisons = 0;
    // one edge with reset high clears the reset edge counters
    reset_n_in = 1'b1;
    {a_gate, b_gate, dir, mbx, a_gen, b_gen, odd, off_hi, off_lo, raw_err} = '0;
    flags_in = '0;
    for (int k = 3; k >= 0; k--) do_reset(k[1:0]);
    for (int k = 0; k < 16; k++) begin
      @(negedge clk_in);
      {odd, a_gen, mbx, dir} = k[3:0];
      b_gen = a_gen;
      {a_gate, b_gate} = 2'b11;
      @(negedge clk_in);
      check(a_oe, !dir);
      check(b_oe, !dir);
      check(a_mb, mbx);
      check(perr, !dir & mbx & a_gen);
      if (!dir) begin
        check(a_out, (a_gen & mbx) ? with_par(A_WORD, odd) : A_WORD);
        check(b_out, b_gen ? with_par(mbx ? B_MAIL : B_FIFO, odd)
              : (mbx ? B_MAIL : B_FIFO));
      end
      pulse_chk(1'b0, dir);
      pulse_chk(1'b1, dir);
    end
    @(negedge clk_in);
    {a_gate, b_gate, raw_err} = 3'b001;
    repeat (14) begin
      @(negedge clk_in);
      check({a_rd, a_wr, b_rd, b_wr}, 4'h0);
    end
    check(perr, 1'b1);
    // a reset too short for four rises per port clock must not complete
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    {a_gate, b_gate} = 2'b11;
    repeat (8) begin
      @(negedge clk_in);
      check({a_rd, a_wr, b_rd, b_wr}, 4'h0);
    end
    check(done, 1'b0);
    check(flags_out, 6'b10_0011);
    tally_and_finish();
  end
endmodule
